// file: rtl/osr_defs.vh
// Constants for the operation status register bank.
// Assumes one device clock and a plain register port.
`ifndef OSR_DEFS_VH
`define OSR_DEFS_VH

// Widths
`define OSR_DW          16
`define OSR_AW          6
`define OSR_NGRP        3

// Group numbers (address bits 4:3)
`define OSR_GRP_OPERATION_SUMMARY_BIT    2'h0
`define OSR_GRP_QUES    2'h1
`define OSR_GRP_INST    2'h2

// Register select within a group (address bits 2:0)
`define OSR_SEL_COND    3'h0
`define OSR_SEL_EVENT   3'h1
`define OSR_SEL_ENABLE  3'h2
`define OSR_SEL_RISE    3'h3
`define OSR_SEL_FALL    3'h4

// Common registers (address bit 5 set, select in bits 2:0)
`define OSR_SEL_STB     3'h0
`define OSR_SEL_ESR     3'h1
`define OSR_SEL_ESE     3'h2
`define OSR_SEL_SRE     3'h3
`define OSR_SEL_CMD     3'h4

// Command register bits
`define OSR_CMD_CLS     0
`define OSR_CMD_PRESET  1
`define OSR_CMD_RST     2

// Status byte bit positions
`define OSR_STB_QUES    3
`define OSR_STB_ESB     5
`define OSR_STB_MSS     6
`define OSR_STB_OPERATION_SUMMARY_BIT    7

// Operation condition bit fed by the instrument subgroup summary
`define OSR_OPERATION_SUMMARY_BIT_INST_BIT 13

// Reset and preset values
`define OSR_ENABLE_RST  16'h0000
`define OSR_RISE_RST    16'h0000
`define OSR_FALL_RST    16'h0000
`define OSR_RISE_PRESET 16'hffff
`define OSR_FALL_PRESET 16'h0000
`define OSR_ENABLE_PRESET 16'h0000

`endif

// file: rtl/osr_group.v
// One status group: condition, filters, latched event, enable mask.
// Assumes the condition input is already on the clk_sys domain.
`timescale 1ns/1ps
`include "osr_defs.vh"
module osr_group #(
  parameter W = `OSR_DW
) (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         nrst,
  // Live condition
  input  wire [W-1:0] cond,
  // Register access
  input  wire [W-1:0] wdata,
  input  wire         wr_enable,
  input  wire         wr_rise,
  input  wire         wr_fall,
  input  wire         rd_event,
  // Commands
  input  wire         cls,
  input  wire         preset,
  // State
  output reg  [W-1:0] event_r,
  output reg  [W-1:0] enable_r,
  output reg  [W-1:0] rise_r,
  output reg  [W-1:0] fall_r,
  output wire         summary
);

  reg  [W-1:0] prev_r;
  wire [W-1:0] rose;
  wire [W-1:0] fell;
  wire [W-1:0] caught;

  // Edges against the previous clock
  assign rose   = cond & ~prev_r;
  assign fell   = ~cond & prev_r;
  // Both filters pass either edge; neither passes none
  assign caught = (rose & rise_r) | (fell & fall_r);

  assign summary = |(event_r & enable_r);

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prev_r   <= {W{1'b0}};
      event_r  <= {W{1'b0}};
      enable_r <= `OSR_ENABLE_RST;
      rise_r   <= `OSR_RISE_RST;
      fall_r   <= `OSR_FALL_RST;
    end else begin
      prev_r <= cond;
      // Latch; set beats read-clear and clear-status
      if (rd_event || cls) begin
        event_r <= caught;
      end else begin
        event_r <= event_r | caught;
      end
      if (preset) begin
        enable_r <= `OSR_ENABLE_PRESET;
        rise_r   <= `OSR_RISE_PRESET;
        fall_r   <= `OSR_FALL_PRESET;
      end else begin
        if (wr_enable) begin
          enable_r <= wdata;
        end
        if (wr_rise) begin
          rise_r <= wdata;
        end
        if (wr_fall) begin
          fall_r <= wdata;
        end
      end
    end
  end

endmodule // osr_group

// file: rtl/osr_top.v
// Operation status register bank with questionable, instrument
// subgroup and standard event groups, and the status byte.
// Assumes condition pins are asynchronous; std_evt_in and the
// register port are on clk_sys.
//
// Operation
// - Operation, questionable, standard event groups provided
// - Event latches filtered transitions until cleared
// - Event read returns value then clears
// - Queries return binary-weighted bit sum
// - Device reset leaves event register alone
// - Condition shows live state, read harmless
// - Condition bit follows its source
// - Device reset keeps still-present condition bits
// - Enable masks event onto summary bit
// - Preset clears enable register
// - Enable writable, readable, default zero
// - Clear-status clears event, keeps enable
// - Falling filter passes one-to-zero edges
// - Rising filter passes zero-to-one edges
// - Preset sets rising, clears falling filter
// - Both filters set pass either edge
// - Both filters clear pass nothing
// - Instrument subgroup behaves like operation group
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`include "osr_defs.vh"
module osr_top #(
  parameter W = `OSR_DW
) (
  // Clock and reset
  input  wire                 clk_sys,
  input  wire                 nrst,
  // Register port
  input  wire [`OSR_AW-1:0]   reg_addr,
  input  wire [W-1:0]         reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [W-1:0]         reg_rdata,
  // Condition pins
  input  wire [W-1:0]         cond_operation_summary_bit_in,
  input  wire [W-1:0]         cond_ques_in,
  input  wire [W-1:0]         cond_inst_in,
  // Standard event pulses
  input  wire [7:0]           std_evt_in,
  // Status outputs
  output wire [7:0]           status_byte,
  output wire                 operation_summary_bit,
  output wire                 service_request,
  output reg                  dev_reset_pulse
);

  localparam NG = `OSR_NGRP;

  // Decode
  wire                 is_common;
  wire [1:0]           grp;
  wire [2:0]           sel;
  wire [NG-1:0]        gsel;
  wire [W-1:0]         cmd_bits;
  wire                 wr_cmd;
  wire                 wr_ese;
  wire                 wr_sre;
  wire                 rd_esr;
  wire [NG-1:0]        wr_enable_v;
  wire [NG-1:0]        wr_rise_v;
  wire [NG-1:0]        wr_fall_v;
  wire [NG-1:0]        rd_event_v;
  wire                 do_cls;
  wire                 do_preset;
  wire                 do_rst;

  // Condition synchronisers
  reg  [NG*W-1:0]      pin_meta_r;
  reg  [NG*W-1:0]      pin_sync_r;
  wire [NG*W-1:0]      pin_raw;
  wire [NG*W-1:0]      cond_all;

  // Group state
  wire [NG*W-1:0]      event_all;
  wire [NG*W-1:0]      enable_all;
  wire [NG*W-1:0]      rise_all;
  wire [NG*W-1:0]      fall_all;
  wire [NG-1:0]        sum_all;

  // Standard event group and service request enable
  reg  [7:0]           esr_r;
  reg  [7:0]           ese_r;
  reg  [7:0]           sre_r;
  wire                 esb;
  reg  [7:0]           stb_raw;
  wire                 mss;
  reg  [7:0]           stb_nxt;
  reg  [7:0]           stb_r;

  // Read path
  reg  [W-1:0]         rd_mux;
  wire [W-1:0]         grp_word;
  reg  [W-1:0]         com_word;
  wire [(NG+1)*W-1:0]  rd_chain;

  assign is_common = reg_addr[5];
  assign grp       = reg_addr[4:3];
  assign sel       = reg_addr[2:0];

  // Common register strobes
  assign wr_cmd = reg_wr && is_common && (sel == `OSR_SEL_CMD);
  assign wr_ese = reg_wr && is_common && (sel == `OSR_SEL_ESE);
  assign wr_sre = reg_wr && is_common && (sel == `OSR_SEL_SRE);
  assign rd_esr = reg_rd && is_common && (sel == `OSR_SEL_ESR);

  // Command register write
  assign cmd_bits  = wr_cmd ? reg_wdata : {W{1'b0}};
  assign do_cls    = cmd_bits[`OSR_CMD_CLS];
  assign do_preset = cmd_bits[`OSR_CMD_PRESET];
  assign do_rst    = cmd_bits[`OSR_CMD_RST];

  assign pin_raw = {cond_inst_in, cond_ques_in, cond_operation_summary_bit_in};

  // Two flip-flops on every condition pin
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_meta_r <= {NG*W{1'b0}};
      pin_sync_r <= {NG*W{1'b0}};
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Condition is the live synchronised source, no latching
  assign cond_all[W-1:0] = pin_sync_r[W-1:0] |
         ({{(W-1){1'b0}}, sum_all[`OSR_GRP_INST]}
          << `OSR_OPERATION_SUMMARY_BIT_INST_BIT);
  assign cond_all[NG*W-1:W] = pin_sync_r[NG*W-1:W];

  // One group per status register set
  genvar g;
  generate
    for (g = 0; g < NG; g = g + 1) begin : grp_gen
      reg [W-1:0] grp_rd_word;

      // Register select and strobes for this group
      assign gsel[g]        = !is_common && ({30'h0, grp} == g);
      assign wr_enable_v[g] = reg_wr && gsel[g] && (sel == `OSR_SEL_ENABLE);
      assign wr_rise_v[g]   = reg_wr && gsel[g] && (sel == `OSR_SEL_RISE);
      assign wr_fall_v[g]   = reg_wr && gsel[g] && (sel == `OSR_SEL_FALL);
      assign rd_event_v[g]  = reg_rd && gsel[g] && (sel == `OSR_SEL_EVENT);

      osr_group #(
        .W (W)
      ) u_grp (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .cond      (cond_all[g*W +: W]),
        .wdata     (reg_wdata),
        .wr_enable (wr_enable_v[g]),
        .wr_rise   (wr_rise_v[g]),
        .wr_fall   (wr_fall_v[g]),
        .rd_event  (rd_event_v[g]),
        .cls       (do_cls),
        .preset    (do_preset),
        .event_r   (event_all[g*W +: W]),
        .enable_r  (enable_all[g*W +: W]),
        .rise_r    (rise_all[g*W +: W]),
        .fall_r    (fall_all[g*W +: W]),
        .summary   (sum_all[g])
      );

      // Read word of this group
      always @* begin
        case (sel)
          `OSR_SEL_COND:   grp_rd_word = cond_all[g*W +: W];
          `OSR_SEL_EVENT:  grp_rd_word = event_all[g*W +: W];
          `OSR_SEL_ENABLE: grp_rd_word = enable_all[g*W +: W];
          `OSR_SEL_RISE:   grp_rd_word = rise_all[g*W +: W];
          `OSR_SEL_FALL:   grp_rd_word = fall_all[g*W +: W];
          default:         grp_rd_word = {W{1'b0}};
        endcase
      end

      assign rd_chain[(g+1)*W +: W] = rd_chain[g*W +: W] |
                                      (gsel[g] ? grp_rd_word : {W{1'b0}});
    end
  endgenerate

  // Standard event group: set wins over read-clear and clear-status
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      esr_r <= 8'h00;
      ese_r <= 8'h00;
      sre_r <= 8'h00;
    end else begin
      if (rd_esr || do_cls) begin
        esr_r <= std_evt_in;
      end else begin
        esr_r <= esr_r | std_evt_in;
      end
      if (wr_ese) begin
        ese_r <= reg_wdata[7:0];
      end
      if (wr_sre) begin
        sre_r <= reg_wdata[7:0];
      end
    end
  end

  assign esb = |(esr_r & ese_r);

  // Status byte assembly
  always @* begin
    stb_raw                = 8'h00;
    stb_raw[`OSR_STB_QUES] = sum_all[`OSR_GRP_QUES];
    stb_raw[`OSR_STB_ESB]  = esb;
    stb_raw[`OSR_STB_OPERATION_SUMMARY_BIT] = sum_all[`OSR_GRP_OPERATION_SUMMARY_BIT];
  end

  assign mss = |(stb_raw & sre_r);

  always @* begin
    stb_nxt               = stb_raw;
    stb_nxt[`OSR_STB_MSS] = mss;
  end

  // Status outputs from flip-flops, one clock behind the groups
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stb_r <= 8'h00;
    end else begin
      stb_r <= stb_nxt;
    end
  end

  assign status_byte           = stb_r;
  assign operation_summary_bit = stb_r[`OSR_STB_OPERATION_SUMMARY_BIT];
  assign service_request       = stb_r[`OSR_STB_MSS];

  // Device reset request: no event or enable state is touched
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dev_reset_pulse <= 1'b0;
    end else begin
      dev_reset_pulse <= do_rst;
    end
  end

  // Group read word: OR of the selected group's word
  assign rd_chain[W-1:0] = {W{1'b0}};
  assign grp_word        = rd_chain[NG*W +: W];

  // Common read word
  always @* begin
    case (sel)
      `OSR_SEL_STB: com_word = {{(W-8){1'b0}}, status_byte};
      `OSR_SEL_ESR: com_word = {{(W-8){1'b0}}, esr_r};
      `OSR_SEL_ESE: com_word = {{(W-8){1'b0}}, ese_r};
      `OSR_SEL_SRE: com_word = {{(W-8){1'b0}}, sre_r};
      default:      com_word = {W{1'b0}};
    endcase
  end

  always @* begin
    rd_mux = is_common ? com_word : grp_word;
  end

  // Read data stands one cycle, bit n weighs two to the n
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= {W{1'b0}};
    end else begin
      reg_rdata <= reg_rd ? rd_mux : {W{1'b0}};
    end
  end

endmodule // osr_top

// file: verif/osr_top_assertions.sv
// Checker for the status register bank, bound to osr_top.
// Assumes one clk_sys domain and the nrst reset.
`timescale 1ns/1ps
module osr_top_assertions #(
  parameter W = 16
) (
  // Clock and reset
  input wire         clk_sys,
  input wire         nrst,
  // Register port
  input wire [5:0]   reg_addr,
  input wire [W-1:0] reg_wdata,
  input wire         reg_wr,
  input wire         reg_rd,
  input wire [W-1:0] reg_rdata,
  // Pins and status
  input wire [W-1:0] cond_operation_summary_bit_in,
  input wire [W-1:0] cond_ques_in,
  input wire [W-1:0] cond_inst_in,
  input wire [7:0]   std_evt_in,
  input wire [7:0]   status_byte,
  input wire         operation_summary_bit,
  input wire         service_request,
  input wire         dev_reset_pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  AST_RD_IDLE: assert property (
    !reg_rd |=> reg_rdata == 16'h0000) else $error("Read data not idle");
  AST_STB_RD: assert property (
    reg_rd && reg_addr == 6'h20 |=> reg_rdata == {8'h00, $past(status_byte)})
    else $error("Status byte read wrong");
  AST_OSB_STB: assert property (
    operation_summary_bit == status_byte[7]) else $error("Summary mismatch");
  AST_DEV_RST: assert property (
    dev_reset_pulse == $past(reg_wr && reg_addr == 6'h24 && reg_wdata[2]))
    else $error("Device reset pulse wrong");
  AST_EN_ZERO: assert property (
    reg_wr && reg_addr == 6'h02 && reg_wdata == 16'h0000
    |=> ##1 !operation_summary_bit) else $error("Summary with mask zero");
  AST_PRESET: assert property (
    reg_wr && reg_addr == 6'h24 && reg_wdata[1]
    |=> ##1 !operation_summary_bit) else $error("Summary after preset");
  AST_EN_RB: assert property (
    reg_wr && reg_addr == 6'h02 ##1 reg_rd && reg_addr == 6'h02
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("Enable readback");
  AST_EVT_CLR: assert property (
    (reg_rd && reg_addr == 6'h01 && $stable(cond_operation_summary_bit_in) &&
     $stable(cond_inst_in)) [*5] |=> reg_rdata == 16'h0000)
    else $error("Event not cleared by read");
  AST_COND_RD: assert property (
    (reg_rd && reg_addr == 6'h00 && $stable(cond_operation_summary_bit_in) &&
     $stable(cond_inst_in)) [*4] |=> reg_rdata == $past(reg_rdata))
    else $error("Condition changed by read");

  cover property (dev_reset_pulse);
  cover property (reg_rd && reg_addr == 6'h01 ##1 reg_rdata != 16'h0000);
  cover property (operation_summary_bit);
endmodule // osr_top_assertions

bind osr_top osr_top_assertions #(.W(W)) u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cond_operation_summary_bit_in(cond_operation_summary_bit_in),
  .cond_ques_in(cond_ques_in), .cond_inst_in(cond_inst_in),
  .std_evt_in(std_evt_in), .status_byte(status_byte),
  .operation_summary_bit(operation_summary_bit),
  .service_request(service_request), .dev_reset_pulse(dev_reset_pulse));

// file: verif/osr_host.sv
// Remote controller model issuing register writes and queries.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/1ps
module osr_host (
  // Clock
  input  wire         clk_sys,
  // Register port
  output logic [5:0]  reg_addr,
  output logic [15:0] reg_wdata,
  output logic        reg_wr,
  output logic        reg_rd,
  input  wire  [15:0] reg_rdata
);
  initial begin
    reg_addr = 6'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task wr_reg(input [5:0] a, input [15:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task rd_reg(input [5:0] a, output [15:0] v);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
endmodule // osr_host

// file: verif/tb_osr_top.sv
// Testbench for the operation status register bank.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
module tb_osr_top;
  logic        clk_sys;
  logic        nrst;
  logic        wr;
  logic        rd;
  logic        osb;
  logic [5:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] co;
  logic [15:0] ci;
  logic [15:0] cq;
  logic [7:0]  se;
  logic [7:0]  sb;
  logic        srq;
  logic [15:0] d;
  int          mismatches;
  int          tests_run;

  osr_host HOST (.clk_sys(clk_sys), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
  osr_top DUT (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .cond_operation_summary_bit_in(co), .cond_ques_in(cq), .cond_inst_in(ci),
    .std_evt_in(se), .status_byte(sb), .operation_summary_bit(osb),
    .service_request(srq), .dev_reset_pulse());

  task ck(input string nm, input [15:0] e, input [15:0] s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task rck(input [5:0] a, input [15:0] e);
    HOST.rd_reg(a, d);
    ck($sformatf("register %h", a), e, d);
  endtask

  task settle;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  task complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    #50000;
    mismatches++;
    complete_run;
  end

  initial begin
    nrst = 1'b0;
    co = 16'h0000;
    ci = 16'h0000;
    cq = 16'h0000;
    se = 8'h00;
    mismatches = 0;
    tests_run = 0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    #1;
    rck(6'h02, 16'h0000);
    rck(6'h03, 16'h0000);
    rck(6'h04, 16'h0000);
    rck(6'h20, 16'h0000);
    $display("test reset values done");
    HOST.wr_reg(6'h03, 16'h0001);
    HOST.wr_reg(6'h02, 16'h0001);
    co <= 16'h0003;
    settle;
    ck("operation_summary_bit", 16'h0001, {15'h0000, osb});
    rck(6'h00, 16'h0003);
    rck(6'h01, 16'h0001);
    for (int i = 0; i < 5; i++) rck(6'h01, 16'h0000);
    for (int i = 0; i < 4; i++) rck(6'h00, 16'h0003);
    $display("test rising filter done");
    HOST.wr_reg(6'h03, 16'h0000);
    HOST.wr_reg(6'h04, 16'h0002);
    co <= 16'h0000;
    settle;
    rck(6'h01, 16'h0002);
    ck("operation_summary_bit", 16'h0000, {15'h0000, osb});
    HOST.wr_reg(6'h03, 16'h0004);
    HOST.wr_reg(6'h04, 16'h0004);
    co <= 16'h0004;
    settle;
    co <= 16'h0000;
    settle;
    rck(6'h01, 16'h0004);
    $display("test falling and both filters done");
    co <= 16'h0004;
    settle;
    HOST.wr_reg(6'h02, 16'h0004);
    @(posedge clk_sys);
    #1;
    ck("operation_summary_bit", 16'h0001, {15'h0000, osb});
    HOST.wr_reg(6'h24, 16'h0001);
    @(posedge clk_sys);
    #1;
    ck("operation_summary_bit", 16'h0000, {15'h0000, osb});
    rck(6'h02, 16'h0004);
    rck(6'h01, 16'h0000);
    $display("test clear status done");
    HOST.wr_reg(6'h24, 16'h0002);
    rck(6'h03, 16'hffff);
    rck(6'h04, 16'h0000);
    rck(6'h02, 16'h0000);
    co <= 16'h000c;
    settle;
    HOST.wr_reg(6'h24, 16'h0004);
    settle;
    rck(6'h00, 16'h000c);
    rck(6'h01, 16'h0008);
    $display("test preset and device reset done");
    HOST.wr_reg(6'h13, 16'h0001);
    ci <= 16'h0001;
    settle;
    rck(6'h10, 16'h0001);
    rck(6'h11, 16'h0001);
    rck(6'h11, 16'h0000);
    HOST.wr_reg(6'h02, 16'h0000);
    rck(6'h02, 16'h0000);
    $display("test instrument subgroup done");
    HOST.wr_reg(6'h23, 16'h0008);
    HOST.wr_reg(6'h0a, 16'h0001);
    cq <= 16'h0001;
    settle;
    rck(6'h20, 16'h0048);
    ck("status_byte", 16'h0048, {8'h00, sb});
    ck("service_request", 16'h0001, {15'h0000, srq});
    rck(6'h09, 16'h0001);
    se <= 8'h04;
    @(posedge clk_sys);
    se <= 8'h00;
    #1;
    rck(6'h21, 16'h0004);
    rck(6'h21, 16'h0000);
    $display("test questionable and standard event done");
    complete_run;
  end
endmodule // tb_osr_top
